/* src/lstc_regs.vh */
// register offsets, field positions, reset values and timing counts
`ifndef LSTC_REGS_VH
`define LSTC_REGS_VH
// register byte offsets
`define LSTC_OFF_CTRL        8'h00
`define LSTC_OFF_EXPTIME     8'h04
`define LSTC_OFF_SOFTTRIG    8'h08
`define LSTC_OFF_STATUS      8'h0C
`define LSTC_OFF_IRQ_STAT    8'h10
`define LSTC_OFF_IRQ_MASK    8'h14
// control register fields
`define LSTC_CTRL_TRIG_EN    0
`define LSTC_CTRL_SRC_LSB    1
`define LSTC_CTRL_SRC_MSB    3
`define LSTC_CTRL_FALLING    4
`define LSTC_CTRL_WIDTH_MODE 5
`define LSTC_CTRL_LPER_EN    6
`define LSTC_CTRL_W          7
// trigger source encodings
`define LSTC_SRC_SOFT        3'h0
`define LSTC_SRC_CC1         3'h1
`define LSTC_SRC_CC4         3'h4
// reset values: line period enable on, source cc1
`define LSTC_CTRL_RST        7'h42
`define LSTC_EXP_RST         24'h00_0BB8
// status fields
`define LSTC_ST_WAIT         0
`define LSTC_ST_EXPOSING     1
// interrupt status fields
`define LSTC_IRQ_START       0
`define LSTC_IRQ_END         1
`define LSTC_IRQ_LOST        2
`define LSTC_IRQ_W           3
// time base and clock
`define LSTC_CLK_PERIOD_NS   100
`define LSTC_TIMEBASE_NS     100
`define LSTC_TICK_CYCLES     (`LSTC_TIMEBASE_NS / `LSTC_CLK_PERIOD_NS)
`define LSTC_EXP_W           24
`endif

/* src/lstc_edge_sync.v */
// trigger input synchroniser with single-cycle edge pulses
`timescale 1ns/1ps
module lstc_edge_sync (
   // clock and reset
   input  wire aclk,
   input  wire aresetn,
   // raw level
   input  wire din,
   // synchronised level and edges
   output wire level,
   output wire rise,
   output wire fall
);
   reg stage1;   // first flop, read by stage2 only
   reg stage2;   // synchronised level
   reg stage3;   // previous level for edge detect

   // two-flop synchroniser and delay stage
   always @(posedge aclk) begin
      if (!aresetn) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // edges last one cycle
   assign level = stage2;
   assign rise  = stage2 & ~stage3;
   assign fall  = ~stage2 & stage3;
endmodule

/* src/lstc_line_trigger.v */
// line start trigger and exposure control with axi4-lite registers
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "lstc_regs.vh"
// Operation
// - soft trigger command self-clears after execution
// - status bit shows waiting for trigger
// - timed exposure equals raw value times 100ns
// - line period enable zero for triggered acquisition
// - selected cc input is the hardware trigger
// - edge select picks rising or falling
// - accepted trigger while waiting starts acquisition
// - leave wait on exposure, return when ready
// - triggers while not waiting are discarded
// - one line per accepted trigger
// - hardware source supports timed and width modes
// - timed exposure begins on selected edge
// - width mode exposes until opposite edge
module lstc_line_trigger (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // camera control inputs cc1..cc4
   input  wire [3:0]  cc_in,
   // acquisition outputs
   output reg         exposure_active,
   output reg         line_start,
   output wire        line_period_enable,
   output reg         irq
);
   // one-hot states
   localparam [2:0] ST_WAIT  = 3'b001;   // waiting for line trigger
   localparam [2:0] ST_TIMED = 3'b010;   // timed exposure running
   localparam [2:0] ST_WIDTH = 3'b100;   // exposure until opposite edge

   reg  [`LSTC_CTRL_W-1:0] ctrl;          // control register
   reg  [`LSTC_EXP_W-1:0]  exp_raw;       // raw exposure time
   reg                     soft_trigger_command; // pending soft trigger
   reg  [`LSTC_IRQ_W-1:0]  irq_stat;      // sticky events
   reg  [`LSTC_IRQ_W-1:0]  irq_mask;      // event enables
   reg  [2:0]              state;         // exposure state
   reg  [`LSTC_EXP_W-1:0]  tick_cnt;      // remaining ticks
   reg  [7:0]              base_cnt;      // clocks per time base tick
   reg  [7:0]              aw_addr;       // latched write address
   reg                     aw_have;       // write address held
   reg  [31:0]             w_data;        // latched write data
   reg  [3:0]              w_strb;        // latched strobes
   reg                     w_have;        // write data held
   wire [3:0]              cc_rise;       // rising edge pulses
   wire [3:0]              cc_fall;       // falling edge pulses

   // per-input synchroniser and edge detect
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_cc
         lstc_edge_sync u_sync (
            .aclk    (aclk),
            .aresetn (aresetn),
            .din     (cc_in[gi]),
            .level   (),
            .rise    (cc_rise[gi]),
            .fall    (cc_fall[gi])
         );
      end
   endgenerate

   // control fields
   wire       trig_en  = ctrl[`LSTC_CTRL_TRIG_EN];
   wire [2:0] src      = ctrl[`LSTC_CTRL_SRC_MSB:`LSTC_CTRL_SRC_LSB];
   wire       falling  = ctrl[`LSTC_CTRL_FALLING];
   wire       width_md = ctrl[`LSTC_CTRL_WIDTH_MODE];
   assign line_period_enable = ctrl[`LSTC_CTRL_LPER_EN];
   wire       waiting_for_line_state = state[0];
   wire       hw_src = (src >= `LSTC_SRC_CC1) && (src <= `LSTC_SRC_CC4);
   wire [1:0] sel = src[1:0] - 2'd1;

   // selected input edges
   wire sel_start = falling ? cc_fall[sel] : cc_rise[sel];
   wire sel_stop  = falling ? cc_rise[sel] : cc_fall[sel];
   // hardware and software trigger requests
   wire trig_gate = trig_en && !line_period_enable;
   wire hw_trig   = trig_gate && hw_src && sel_start;
   wire sw_trig   = trig_gate && (src == `LSTC_SRC_SOFT) &&
                    soft_trigger_command;
   wire any_trig  = hw_trig || sw_trig;
   wire accept    = any_trig && waiting_for_line_state;
   wire lost      = hw_trig && !waiting_for_line_state;
   wire tick      = (base_cnt == `LSTC_TICK_CYCLES - 1);
   wire timed_end = state[1] && tick && (tick_cnt <= 1);
   wire width_end = state[2] && sel_stop;
   wire exp_end   = timed_end || width_end;

   // time base divider: one tick per 100 ns
   always @(posedge aclk) begin
      if (!aresetn || accept) begin
         base_cnt <= 8'h00;
      end else if (tick) begin
         base_cnt <= 8'h00;
      end else begin
         base_cnt <= base_cnt + 8'h01;
      end
   end

   // exposure state machine
   always @(posedge aclk) begin
      if (!aresetn) begin
         state           <= ST_WAIT;
         tick_cnt        <= {`LSTC_EXP_W{1'b0}};
         exposure_active <= 1'b0;
         line_start      <= 1'b0;
      end else begin
         line_start <= accept;
         case (state)
            ST_WAIT: begin
               if (accept) begin
                  exposure_active <= 1'b1;
                  tick_cnt        <= exp_raw;
                  // software trigger is always timed
                  if (width_md && hw_trig) begin
                     state <= ST_WIDTH;
                  end else begin
                     state <= ST_TIMED;
                  end
               end
            end
            ST_TIMED: begin
               if (timed_end) begin
                  state           <= ST_WAIT;
                  exposure_active <= 1'b0;
               end else if (tick) begin
                  tick_cnt <= tick_cnt - 1'b1;
               end
            end
            ST_WIDTH: begin
               if (width_end) begin
                  state           <= ST_WAIT;
                  exposure_active <= 1'b0;
               end
            end
            default: begin
               state           <= ST_WAIT;
               exposure_active <= 1'b0;
            end
         endcase
      end
   end

   // axi write channel handshakes
   assign s_axi_awready = !aw_have && !s_axi_bvalid;
   assign s_axi_wready  = !w_have && !s_axi_bvalid;
   wire do_write = aw_have && w_have && !s_axi_bvalid;
   wire wr_ctrl  = do_write && aw_addr == `LSTC_OFF_CTRL;
   wire wr_exp   = do_write && aw_addr == `LSTC_OFF_EXPTIME;
   wire wr_soft  = do_write && aw_addr == `LSTC_OFF_SOFTTRIG;
   wire wr_istat = do_write && aw_addr == `LSTC_OFF_IRQ_STAT;
   wire wr_imask = do_write && aw_addr == `LSTC_OFF_IRQ_MASK;
   wire mapped   = wr_ctrl || wr_exp || wr_soft || wr_istat || wr_imask ||
                   aw_addr == `LSTC_OFF_STATUS;

   // write path: latch address and data, then commit
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have      <= 1'b0;
         w_have       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration registers with byte strobes
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl     <= `LSTC_CTRL_RST;
         exp_raw  <= `LSTC_EXP_RST;
         irq_mask <= {`LSTC_IRQ_W{1'b0}};
      end else begin
         if (wr_ctrl && w_strb[0]) begin
            ctrl <= w_data[`LSTC_CTRL_W-1:0];
         end
         if (wr_exp && w_strb[0]) begin
            exp_raw[7:0] <= w_data[7:0];
         end
         if (wr_exp && w_strb[1]) begin
            exp_raw[15:8] <= w_data[15:8];
         end
         if (wr_exp && w_strb[2]) begin
            exp_raw[23:16] <= w_data[23:16];
         end
         if (wr_imask && w_strb[0]) begin
            irq_mask <= w_data[`LSTC_IRQ_W-1:0];
         end
      end
   end

   // soft trigger command: set by software, cleared on the next cycle whether executed or not
   always @(posedge aclk) begin
      if (!aresetn) begin
         soft_trigger_command <= 1'b0;
      end else if (wr_soft && w_strb[0] && w_data[0]) begin
         soft_trigger_command <= 1'b1;
      end else if (soft_trigger_command) begin
         // executed, or dropped when not accepted
         soft_trigger_command <= 1'b0;
      end
   end

   // sticky interrupt status, set wins over write-one-to-clear
   wire [`LSTC_IRQ_W-1:0] ev = {lost, exp_end, accept};
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= {`LSTC_IRQ_W{1'b0}};
         irq      <= 1'b0;
      end else begin
         irq_stat <= (irq_stat &
                      ~((wr_istat && w_strb[0]) ?
                        w_data[`LSTC_IRQ_W-1:0] : {`LSTC_IRQ_W{1'b0}}))
                     | ev;
         irq      <= |(irq_stat & irq_mask);
      end
   end

   // read path
   assign s_axi_arready = !s_axi_rvalid;
   reg [31:0] rd_mux;
   reg        rd_ok;
   always @* begin
      rd_mux = 32'h0000_0000;
      rd_ok  = 1'b1;
      case (s_axi_araddr)
         `LSTC_OFF_CTRL:     rd_mux[`LSTC_CTRL_W-1:0] = ctrl;
         `LSTC_OFF_EXPTIME:  rd_mux[`LSTC_EXP_W-1:0] = exp_raw;
         `LSTC_OFF_SOFTTRIG: rd_mux[0] = soft_trigger_command;
         `LSTC_OFF_STATUS: begin
            rd_mux[`LSTC_ST_WAIT]     = waiting_for_line_state;
            rd_mux[`LSTC_ST_EXPOSING] = exposure_active;
         end
         `LSTC_OFF_IRQ_STAT: rd_mux[`LSTC_IRQ_W-1:0] = irq_stat;
         `LSTC_OFF_IRQ_MASK: rd_mux[`LSTC_IRQ_W-1:0] = irq_mask;
         default:            rd_ok = 1'b0;
      endcase
   end

   // read data register
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

/* testbench/lstc_fg_model.sv */
// frame grabber model driving the camera control lines
`timescale 1ns/1ps
module lstc_fg_model (
   // clock
   input  wire       aclk,
   // chosen line and its active edge
   input  wire [1:0] sel,
   input  wire       fall,
   // camera control lines
   output reg  [3:0] cc_in
);
   reg act;  // trigger asserted
   initial begin
      act = 1'h0;
      cc_in = 4'h0;
   end
   // other lines toggle as noise, the chosen one follows act
   always @(posedge aclk) begin
      cc_in <= ~cc_in;
      cc_in[sel] <= act ^ fall;
   end
   // hold the active level for n whole cycles of 100 ns
   task pulse(input int n);
      act <= 1'h1;
      repeat (n) @(posedge aclk);
      act <= 1'h0;
   endtask
endmodule

/* testbench/lstc_line_trigger_chk.sv */
// port assertions for the line start trigger block
`timescale 1ns/1ps
module lstc_line_trigger_chk (
   // clock and reset
   input wire        aclk,
   input wire        aresetn,
   // bus outputs and the bready, rready inputs
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        s_axi_arready,
   // acquisition outputs
   input wire        exposure_active,
   input wire        line_start,
   input wire        line_period_enable
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_start_single: assert property (line_start |=> !line_start)
      else $error("line start wider than one cycle");
   a_rise_starts: assert property (
      $rose(exposure_active) |-> line_start)
      else $error("exposure began without line start");
   a_start_exposes: assert property (line_start |-> exposure_active)
      else $error("line start without exposure");
   a_idle_accept: assert property (
      line_start |-> !$past(exposure_active))
      else $error("trigger taken during exposure");
   a_lpe_blocks: assert property (
      line_start |-> !$past(line_period_enable))
      else $error("trigger taken with internal timing on");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_ar_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
endmodule
bind lstc_line_trigger lstc_line_trigger_chk i_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_arready(s_axi_arready),
   .exposure_active(exposure_active), .line_start(line_start),
   .line_period_enable(line_period_enable)
);

/* testbench/lstc_line_trigger_tb.sv */
// self-checking bench for the line start trigger block
`timescale 1ns/1ps
module lstc_line_trigger_tb;
   reg         aclk, aresetn;         // clock and reset
   reg  [7:0]  awaddr, araddr;        // bus addresses
   reg         awvalid, wvalid;       // write requests
   reg         bready, arvalid, rready;
   reg  [31:0] wdata;                 // write data
   reg  [1:0]  sel;                   // model line select
   reg         fall;                  // model edge select
   wire        awready, wready, bvalid, arready, rvalid;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [3:0]  cc_in;
   wire        exposure_active, line_start, line_period_enable, irq;
   int         errors, n_checks, lines, expc, l0, e0;
   lstc_line_trigger i_lstc_line_trigger (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cc_in(cc_in),
      .exposure_active(exposure_active), .line_start(line_start),
      .line_period_enable(line_period_enable), .irq(irq)
   );
   lstc_fg_model i_lstc_fg_model (
      .aclk(aclk), .sel(sel), .fall(fall), .cc_in(cc_in)
   );
   // count line starts and exposure cycles
   always @(posedge aclk) begin
      lines <= lines + line_start;
      expc <= expc + exposure_active;
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   // one bus write, address and data offered together
   task wr(input logic [7:0] a, input logic [31:0] d,
           input logic [1:0] r = 2'h0);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      fork
         begin do @(posedge aclk); while (!awready); awvalid <= 1'h0; end
         begin do @(posedge aclk); while (!wready); wvalid <= 1'h0; end
      join
      while (!bvalid) @(posedge aclk);
      bready <= 1'h0;
      chk(bresp, r);
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d,
           output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      while (!rvalid) @(posedge aclk);
      rready <= 1'h0;
      d = rdata;
      r = rresp;
   endtask
   // disable, move the model to a new line, then apply control
   task cfg(input logic [1:0] s, input logic f, input logic [31:0] c);
      wr(8'h00, 32'h0000_0000);
      sel <= s;
      fall <= f;
      repeat (4) @(posedge aclk);
      wr(8'h00, c);
   endtask
   // trigger (soft when n is zero), wait, compare lines and exposure
   task fire(input int n, input int w, input int el, input int ee);
      l0 = lines;
      e0 = expc;
      if (n == 0) wr(8'h08, 32'h0000_0001);
      else i_lstc_fg_model.pulse(n);
      repeat (w) @(posedge aclk);
      chk(lines - l0, el);
      chk(expc - e0, ee);
   endtask
   task t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rd(8'h00, d, r);
      chk(d, 32'h0000_0042);
      rd(8'h04, d, r);
      chk(d, 32'h0000_0BB8);
      chk(line_period_enable, 1'h1);
      rd(8'h18, d, r);
      chk(r, 2'h2);
      wr(8'h18, 32'h0000_0001, 2'h2);
      $display("t_reset done");
   endtask
   task t_soft;
      logic [31:0] d;
      logic [1:0]  r;
      cfg(2'h0, 1'h0, 32'h0000_0001);
      wr(8'h04, 32'h0000_0014);
      chk(line_period_enable, 1'h0);
      fire(0, 30, 1, 20);
      rd(8'h08, d, r);
      chk(d, 32'h0000_0000);
      rd(8'h0C, d, r);
      chk(d, 32'h0000_0001);
      $display("t_soft done");
   endtask
   task t_hw;
      wr(8'h04, 32'h0000_0014);
      for (int s = 1; s <= 4; s++) begin
         for (int f = 0; f < 2; f++) begin
            cfg(2'(s - 1), 1'(f), 32'(1 | s << 1 | f << 4));
            fire(2, 30, 1, 20);
         end
      end
      $display("t_hw done");
   endtask
   task t_over;
      logic [31:0] d;
      logic [1:0]  r;
      cfg(2'h0, 1'h0, 32'h0000_0003);
      wr(8'h04, 32'h0000_0014);
      wr(8'h10, 32'h0000_0007);
      wr(8'h14, 32'h0000_0000);
      l0 = lines;
      i_lstc_fg_model.pulse(2);
      repeat (8) @(posedge aclk);
      rd(8'h0C, d, r);
      chk(d, 32'h0000_0002);
      i_lstc_fg_model.pulse(2);
      repeat (30) @(posedge aclk);
      chk(lines - l0, 1);
      rd(8'h10, d, r);
      chk(d, 32'h0000_0007);
      chk(irq, 1'h0);
      wr(8'h14, 32'h0000_0004);
      repeat (2) @(posedge aclk);
      chk(irq, 1'h1);
      wr(8'h10, 32'h0000_0004);
      repeat (2) @(posedge aclk);
      chk(irq, 1'h0);
      rd(8'h10, d, r);
      chk(d, 32'h0000_0003);
      $display("t_over done");
   endtask
   task t_width;
      cfg(2'h0, 1'h0, 32'h0000_0023);
      fire(7, 20, 1, 7);
      wr(8'h00, 32'h0000_0043);
      chk(line_period_enable, 1'h1);
      fire(2, 10, 0, 0);
      $display("t_width done");
   endtask
   task results;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      aclk = 1'h0;
      forever #50 aclk = ~aclk;
   end
   // cut a hang short well past the expected run
   initial begin
      #500_000;
      errors++;
      results;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, sel, fall} = 51'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset;
      t_soft;
      t_hw;
      t_over;
      t_width;
      results;
   end
endmodule
